// ---- include/cpld_pkg.sv ----
// constants, configuration layout and bus carriers of the macrocell array
// assumes one 250 MHz clock and an AXI4-Lite master that loads configuration
// What this block does
// - five product terms see global and regional buses
// - allocator routes each term to sum or control
// - global bus carries pins and all feedbacks
// - switch matrix picks 40 global bus signals
// - or gate sums five terms, cascade to forty
// - four cascade chains of forty terms each
// - xor second operand: term, high or low
// - data from xor, product term or pin
// - storage acts as d, t, jk, sr, latch
// - latch passes while clock high, holds low
// - clock: three global lines or term, rising
// - clock enable term low ignores global edges
// - clear: global, term, both ored, or off
// - set: product term or off
// - output and feedback each registered or combinatorial
// - each pin input, output or bidirectional
// - enable from enable pins, pins or macrocells
// - foldback inverts one term onto regional bus
// - dedicated pins serve as clock, clear, enable
// - user signature readable whatever the lock
package cpld_pkg;
  localparam int NUM_MC     = 32;
  localparam int MC_PER_BLK = 16;
  localparam int NUM_BLK    = 2;
  localparam int PT_PER_MC  = 5;
  localparam int NUM_DED    = 4;
  localparam int NUM_IO     = 32;
  localparam int SM_OUT     = 40;
  localparam int PT_IN      = 56;
  localparam int GBUS_W     = 68;
  localparam int CHAIN_LEN  = 8;
  localparam int CLEAR_PIN  = 3;
  localparam int CLR_GLOBAL_BIT = 0;
  localparam int CLR_PT_BIT     = 1;

  localparam logic [6:0]  GBUS_SEL_LIMIT = 7'h44;
  localparam logic [6:0]  SM_BLK_OFFSET  = 7'h28;
  localparam logic [5:0]  SM_IDX_LIMIT   = 6'h28;
  localparam logic [2:0]  PT_IDX_LIMIT   = 3'h5;
  localparam logic [1:0]  CLK_PT         = 2'h3;

  localparam logic [3:0]  PT_REGION   = 4'h0;
  localparam logic [8:0]  CTRL_REGION = 9'h020;
  localparam logic [6:0]  SW_REGION   = 7'h0a;
  localparam logic [15:0] SIG_ADDR    = 16'h1800;
  localparam logic [15:0] LOCK_ADDR   = 16'h1804;
  localparam logic [15:0] QSTAT_ADDR  = 16'h1808;
  localparam logic [15:0] OSTAT_ADDR  = 16'h180c;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [55:0] MASK_RESET = 56'h00_0000_0000_0000;
  localparam logic [6:0]  SW_RESET   = 7'h00;
  localparam logic [15:0] SIG_RESET  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {FF_D, FF_T, FF_JK, FF_SR, FF_LATCH} ff_mode_type;
  typedef enum logic [2:0] {OE_OFF, OE_ON, OE_PIN, OE_IO, OE_MC} oe_mode_type;
  typedef enum logic [1:0] {XOR_LOW, XOR_HIGH, XOR_PT} xor_sel_type;
  typedef enum logic [1:0] {D_XOR, D_PT, D_PIN} d_sel_type;
  typedef enum logic [3:0] {
    REG_NONE, REG_PT, REG_CTRL, REG_SW, REG_SIG, REG_LOCK, REG_QSTAT, REG_OSTAT
  } region_type;

  typedef struct packed {
    logic [4:0]  pt_to_sum;
    xor_sel_type xor_sel;
    d_sel_type   d_sel;
    ff_mode_type ff_mode;
    logic [1:0]  clk_sel;
    logic        ce_en;
    logic [1:0]  clr_sel;
    logic        set_en;
    logic        out_reg;
    logic        fb_reg;
    oe_mode_type oe_mode;
    logic        oe_inv;
    logic [3:0]  oe_src;
    logic [2:0]  fold_sel;
    logic        casc_en;
  } mc_ctrl_type;

  typedef struct packed {
    region_type region;
    logic [4:0] mc;
    logic [2:0] pt;
    logic [1:0] word;
    logic       blk;
    logic [5:0] idx;
  } addr_dec_type;

  typedef struct packed {
    logic [15:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [15:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_type;
endpackage : cpld_pkg

// ---- hw/pin_sync.sv ----
// three-stage synchroniser for pin inputs
// assumes inputs asynchronous to ref_clk_i
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input  logic         ref_clk_i,
  input  logic         rst_n_i,
  input  logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_o <= '0;
    end else begin
      sync_o <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & sync_o);
    end
  end
endmodule : pin_sync

// ---- hw/storage_cell.sv ----
// one macrocell storage element: d, t, jk, sr or transparent latch
// assumes control levels sampled on ref_clk_i; clock edge found by compare
`timescale 1ns/1ns
module storage_cell
  import cpld_pkg::*;
(
  input  logic        ref_clk_i,
  input  logic        rst_n_i,
  input  ff_mode_type mode_i,
  input  logic        d_i,
  input  logic        k_i,
  input  logic        clk_lvl_i,
  input  logic        ce_i,
  input  logic        clr_i,
  input  logic        set_i,
  output logic        q_o
);
  logic q;
  logic clk_prev;
  logic edge_ok;
  logic next_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_lvl_i;
    end
  end

  assign edge_ok = clk_lvl_i & ~clk_prev & ce_i;

  always_comb begin
    next_q = q;
    if (clr_i) begin
      next_q = 1'b0;
    end else if (set_i) begin
      next_q = 1'b1;
    end else begin
      unique case (mode_i)
        FF_D:     if (edge_ok) next_q = d_i;
        FF_T:     if (edge_ok && d_i) next_q = ~q;
        FF_JK:    if (edge_ok) next_q = (d_i & ~q) | (~k_i & q);
        FF_SR:    if (edge_ok) next_q = d_i | (~k_i & q);
        FF_LATCH: if (clk_lvl_i && ce_i) next_q = d_i;
        default:  next_q = q;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // latch flows through while open
  assign q_o = (mode_i == FF_LATCH) ? next_q : q;
endmodule : storage_cell

// ---- hw/cpld_logic_macrocell.sv ----
// two logic blocks of sixteen macrocells with switch matrix and config slave
// assumes an AXI4-Lite master; pins are asynchronous and synchronised here
`timescale 1ns/1ns
module cpld_logic_macrocell
  import cpld_pkg::*;
(
  input  logic        ref_clk_i,
  input  logic        rst_n_i,
  input  axi_req_type axi_req_i,
  output axi_rsp_type axi_rsp_o,
  input  logic [3:0]  ded_in_i,
  input  logic [31:0] io_in_i,
  output logic [31:0] io_out_o,
  output logic [31:0] io_oe_o
);
  logic [55:0]  pt_true [NUM_MC][PT_PER_MC];
  logic [55:0]  pt_comp [NUM_MC][PT_PER_MC];
  mc_ctrl_type  mc_ctrl [NUM_MC];
  logic [6:0]   sw_sel [NUM_BLK*SM_OUT];
  logic [15:0]  signature;
  logic         locked;

  logic [3:0]   ded_s;
  logic [31:0]  io_s;
  logic [67:0]  gbus_q;
  logic [31:0]  fold_q;
  logic [79:0]  sm;
  logic [31:0]  sum_w;
  logic [31:0]  xo_w;
  logic [31:0]  q_w;
  logic [31:0]  out_w;
  logic [31:0]  fb_w;
  logic [31:0]  fold_w;
  logic [31:0]  oe_w;

  logic         aw_hold;
  logic [15:0]  aw_addr_q;
  logic         w_hold;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;
  logic         b_valid;
  logic [1:0]   b_resp;
  logic         r_valid;
  logic [31:0]  r_data;
  logic [1:0]   r_resp;
  logic         wr_fire;
  logic         ar_take;
  addr_dec_type wr_dec;
  addr_dec_type rd_dec;
  logic [31:0]  wr_old;
  logic [31:0]  wr_new;
  logic [31:0]  rd_word;

  function automatic addr_dec_type decode(input logic [15:0] a);
    addr_dec_type d;
    d        = '0;
    d.region = REG_NONE;
    if (a[15:12] == PT_REGION) begin
      d.mc   = a[11:7];
      d.pt   = a[6:4];
      d.word = a[3:2];
      if (a[6:4] < PT_IDX_LIMIT) begin
        d.region = REG_PT;
      end
    end else if (a[15:7] == CTRL_REGION) begin
      d.mc     = a[6:2];
      d.region = REG_CTRL;
    end else if (a[15:9] == SW_REGION) begin
      d.blk = a[8];
      d.idx = a[7:2];
      if (a[7:2] < SM_IDX_LIMIT) begin
        d.region = REG_SW;
      end
    end else if (a[15:2] == SIG_ADDR[15:2]) begin
      d.region = REG_SIG;
    end else if (a[15:2] == LOCK_ADDR[15:2]) begin
      d.region = REG_LOCK;
    end else if (a[15:2] == QSTAT_ADDR[15:2]) begin
      d.region = REG_QSTAT;
    end else if (a[15:2] == OSTAT_ADDR[15:2]) begin
      d.region = REG_OSTAT;
    end
    return d;
  endfunction : decode

  function automatic logic [6:0] sw_index(input logic blk,
                                          input logic [5:0] idx);
    return blk ? 7'(idx) + SM_BLK_OFFSET : 7'(idx);
  endfunction : sw_index

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic pt_eval(input logic [55:0] in,
                                   input logic [55:0] t,
                                   input logic [55:0] c);
    return &((~t | in) & (~c | ~in));
  endfunction : pt_eval

  function automatic logic [31:0] reg_word(input addr_dec_type d);
    logic [31:0] r;
    r = '0;
    unique case (d.region)
      REG_PT: begin
        unique case (d.word)
          2'h0: r = pt_true[d.mc][d.pt][31:0];
          2'h1: r = {8'h00, pt_true[d.mc][d.pt][55:32]};
          2'h2: r = pt_comp[d.mc][d.pt][31:0];
          2'h3: r = {8'h00, pt_comp[d.mc][d.pt][55:32]};
        endcase
      end
      REG_CTRL:  r = mc_ctrl[d.mc];
      REG_SW:    r = {25'h000_0000, sw_sel[sw_index(d.blk, d.idx)]};
      REG_SIG:   r = {16'h0000, signature};
      REG_LOCK:  r = {31'h0000_0000, locked};
      REG_QSTAT: r = q_w;
      REG_OSTAT: r = out_w;
      default:   r = '0;
    endcase
    return r;
  endfunction : reg_word

  // pin synchronisers
  pin_sync #(.W(NUM_DED)) u_ded_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ded_in_i),
    .sync_o    (ded_s)
  );

  pin_sync #(.W(NUM_IO)) u_io_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (io_in_i),
    .sync_o    (io_s)
  );

  // configuration slave, write side
  assign wr_fire = aw_hold & w_hold & ~b_valid;
  assign wr_dec  = decode(aw_addr_q);
  assign rd_dec  = decode(axi_req_i.araddr);
  assign ar_take = axi_req_i.arvalid & ~r_valid;

  always_comb begin
    wr_old = reg_word(wr_dec);
  end

  assign wr_new = merge(wr_old, w_data_q, w_strb_q);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold   <= 1'b0;
      aw_addr_q <= '0;
    end else if (axi_req_i.awvalid && !aw_hold) begin
      aw_hold   <= 1'b1;
      aw_addr_q <= axi_req_i.awaddr;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_hold   <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (axi_req_i.wvalid && !w_hold) begin
      w_hold   <= 1'b1;
      w_data_q <= axi_req_i.wdata;
      w_strb_q <= axi_req_i.wstrb;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      b_valid <= 1'b0;
      b_resp  <= RESP_OKAY;
    end else if (wr_fire) begin
      b_valid <= 1'b1;
      if (wr_dec.region == REG_NONE || wr_dec.region == REG_QSTAT ||
          wr_dec.region == REG_OSTAT) begin
        b_resp <= RESP_SLVERR;
      end else begin
        b_resp <= RESP_OKAY;
      end
    end else if (axi_req_i.bready) begin
      b_valid <= 1'b0;
    end
  end

  // static selection settings
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_MC; i++) begin
        for (int j = 0; j < PT_PER_MC; j++) begin
          pt_true[i][j] <= MASK_RESET;
          pt_comp[i][j] <= MASK_RESET;
        end
      end
    end else if (wr_fire && wr_dec.region == REG_PT) begin
      unique case (wr_dec.word)
        2'h0: pt_true[wr_dec.mc][wr_dec.pt][31:0]  <= wr_new;
        2'h1: pt_true[wr_dec.mc][wr_dec.pt][55:32] <= wr_new[23:0];
        2'h2: pt_comp[wr_dec.mc][wr_dec.pt][31:0]  <= wr_new;
        2'h3: pt_comp[wr_dec.mc][wr_dec.pt][55:32] <= wr_new[23:0];
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_MC; i++) begin
        mc_ctrl[i] <= mc_ctrl_type'(CTRL_RESET);
      end
    end else if (wr_fire && wr_dec.region == REG_CTRL) begin
      mc_ctrl[wr_dec.mc] <= mc_ctrl_type'(wr_new);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_BLK*SM_OUT; i++) begin
        sw_sel[i] <= SW_RESET;
      end
    end else if (wr_fire && wr_dec.region == REG_SW) begin
      sw_sel[sw_index(wr_dec.blk, wr_dec.idx)] <= wr_new[6:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      signature <= SIG_RESET;
    end else if (wr_fire && wr_dec.region == REG_SIG) begin
      signature <= wr_new[15:0];
    end
  end

  // lock only clears with reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked <= 1'b0;
    end else if (wr_fire && wr_dec.region == REG_LOCK && wr_new[0]) begin
      locked <= 1'b1;
    end
  end

  // configuration slave, read side
  always_comb begin
    rd_word = reg_word(rd_dec);
    if (locked && (rd_dec.region == REG_PT || rd_dec.region == REG_CTRL ||
                   rd_dec.region == REG_SW)) begin
      rd_word = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_valid <= 1'b0;
      r_data  <= '0;
      r_resp  <= RESP_OKAY;
    end else if (ar_take) begin
      r_valid <= 1'b1;
      r_data  <= rd_word;
      r_resp  <= (rd_dec.region == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (axi_req_i.rready) begin
      r_valid <= 1'b0;
    end
  end

  assign axi_rsp_o.awready = ~aw_hold;
  assign axi_rsp_o.wready  = ~w_hold;
  assign axi_rsp_o.bvalid  = b_valid;
  assign axi_rsp_o.bresp   = b_resp;
  assign axi_rsp_o.arready = ~r_valid;
  assign axi_rsp_o.rvalid  = r_valid;
  assign axi_rsp_o.rdata   = r_data;
  assign axi_rsp_o.rresp   = r_resp;

  // global and regional buses, registered to break feedback loops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gbus_q <= '0;
      fold_q <= '0;
    end else begin
      gbus_q <= {fb_w, io_s, ded_s};
      fold_q <= fold_w;
    end
  end

  // switch matrix
  for (genvar s = 0; s < NUM_BLK*SM_OUT; s++) begin : g_sm
    assign sm[s] = (sw_sel[s] < GBUS_SEL_LIMIT) ?
                   gbus_q[sw_sel[s]] : 1'b0;
  end

  // macrocells
  for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
    localparam int BLK = m / MC_PER_BLK;
    mc_ctrl_type      ctl;
    logic [PT_IN-1:0] pt_in;
    logic [4:0]       pt;
    logic [4:0]       ctrl_pt;
    logic             casc_in;
    logic             xor_b;
    logic             data;
    logic             clk_lvl;
    logic             ce;
    logic             clr;
    logic             set;

    assign ctl   = mc_ctrl[m];
    assign pt_in = {fold_q[BLK*MC_PER_BLK +: MC_PER_BLK],
                    sm[BLK*SM_OUT +: SM_OUT]};

    for (genvar k = 0; k < PT_PER_MC; k++) begin : g_pt
      assign pt[k] = pt_eval(pt_in, pt_true[m][k], pt_comp[m][k]);
    end

    assign ctrl_pt = pt & ~ctl.pt_to_sum;

    if (m % CHAIN_LEN == 0) begin : g_head
      assign casc_in = 1'b0;
    end else begin : g_link
      assign casc_in = sum_w[m-1];
    end

    assign sum_w[m] = |(pt & ctl.pt_to_sum) | (ctl.casc_en & casc_in);

    always_comb begin
      unique case (ctl.xor_sel)
        XOR_LOW:  xor_b = 1'b0;
        XOR_HIGH: xor_b = 1'b1;
        XOR_PT:   xor_b = ctrl_pt[0];
        default:  xor_b = 1'b0;
      endcase
    end

    assign xo_w[m] = sum_w[m] ^ xor_b;

    always_comb begin
      unique case (ctl.d_sel)
        D_XOR:   data = xo_w[m];
        D_PT:    data = ctrl_pt[1];
        D_PIN:   data = io_s[m];
        default: data = xo_w[m];
      endcase
    end

    assign clk_lvl = (ctl.clk_sel == CLK_PT) ? ctrl_pt[2]
                                             : ded_s[ctl.clk_sel];
    assign ce  = (ctl.clk_sel != CLK_PT && ctl.ce_en) ? ctrl_pt[2]
                                                      : 1'b1;
    assign clr = (ctl.clr_sel[CLR_GLOBAL_BIT] & ded_s[CLEAR_PIN]) |
                 (ctl.clr_sel[CLR_PT_BIT] & ctrl_pt[3]);
    assign set = ctl.set_en & ctrl_pt[4];

    storage_cell u_cell (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .mode_i    (ctl.ff_mode),
      .d_i       (data),
      .k_i       (ctrl_pt[1]),
      .clk_lvl_i (clk_lvl),
      .ce_i      (ce),
      .clr_i     (clr),
      .set_i     (set),
      .q_o       (q_w[m])
    );

    assign out_w[m] = ctl.out_reg ? q_w[m] : xo_w[m];
    assign fb_w[m]  = ctl.fb_reg ? q_w[m] : xo_w[m];
    assign fold_w[m] = (ctl.fold_sel < PT_IDX_LIMIT) ?
                       ~pt[ctl.fold_sel] : 1'b0;

    always_comb begin
      unique case (ctl.oe_mode)
        OE_OFF:  oe_w[m] = 1'b0;
        OE_ON:   oe_w[m] = 1'b1;
        OE_PIN:  oe_w[m] = ded_s[ctl.oe_src[0]] ^ ctl.oe_inv;
        OE_IO:   oe_w[m] = io_s[{1'(BLK), ctl.oe_src}] ^ ctl.oe_inv;
        OE_MC:   oe_w[m] = out_w[{1'(BLK), ctl.oe_src}] ^ ctl.oe_inv;
        default: oe_w[m] = 1'b0;
      endcase
    end
  end

  // pin drivers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_out_o <= '0;
      io_oe_o  <= '0;
    end else begin
      io_out_o <= out_w;
      io_oe_o  <= oe_w;
    end
  end
endmodule : cpld_logic_macrocell

// ---- tb/cpld_logic_macrocell_properties.sv ----
// bus handshake and signature checks on the macrocell array ports
// assumes bind onto cpld_logic_macrocell; one clock domain
`timescale 1ns/1ns
module cpld_logic_macrocell_properties
  import cpld_pkg::*;
(
  input logic        ref_clk_i,
  input logic        rst_n_i,
  input axi_req_type axi_req_i,
  input axi_rsp_type axi_rsp_o,
  input logic [3:0]  ded_in_i,
  input logic [31:0] io_in_i,
  input logic [31:0] io_out_o,
  input logic [31:0] io_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence aw_w_taken;
    axi_req_i.awvalid && axi_rsp_o.awready &&
    axi_req_i.wvalid && axi_rsp_o.wready;
  endsequence
  sequence ar_taken;
    axi_req_i.arvalid && axi_rsp_o.arready;
  endsequence

  arready_rvalid_a: assert property (
    axi_rsp_o.arready == !axi_rsp_o.rvalid)
    else $error("arready not the inverse of rvalid");
  read_hold_a: assert property (
    axi_rsp_o.rvalid && !axi_req_i.rready |=>
    axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
    else $error("read answer dropped before rready");
  write_hold_a: assert property (
    axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid)
    else $error("write answer dropped before bready");
  read_latency_a: assert property (
    ar_taken |=> axi_rsp_o.rvalid)
    else $error("read answer late");
  write_latency_a: assert property (
    aw_w_taken |=> !axi_rsp_o.bvalid ##1 axi_rsp_o.bvalid)
    else $error("write answer not two edges after request");
  ro_write_err_a: assert property (
    aw_w_taken ##0 (axi_req_i.awaddr == QSTAT_ADDR) |->
    ##2 axi_rsp_o.bresp == RESP_SLVERR)
    else $error("write to status word not refused");
  slverr_zero_a: assert property (
    axi_rsp_o.rvalid && axi_rsp_o.rresp == RESP_SLVERR |->
    axi_rsp_o.rdata == 32'h0000_0000)
    else $error("refused read returned data");
  sig_read_ok_a: assert property (
    ar_taken ##0 (axi_req_i.araddr == SIG_ADDR) |=>
    axi_rsp_o.rresp == RESP_OKAY)
    else $error("signature read refused");
endmodule : cpld_logic_macrocell_properties

bind cpld_logic_macrocell cpld_logic_macrocell_properties checker_u (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .axi_req_i(axi_req_i),
  .axi_rsp_o(axi_rsp_o), .ded_in_i(ded_in_i), .io_in_i(io_in_i),
  .io_out_o(io_out_o), .io_oe_o(io_oe_o));

// ---- tb/cpld_logic_macrocell_test.sv ----
// directed bench: configures macrocell 0 over the bus, drives pins
// assumes the design's register map and a 12-cycle pin settle time
`timescale 1ns/1ns
module test_cpld_logic_macrocell
  import cpld_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  axi_req_type axi_req_i;
  axi_rsp_type axi_rsp_o;
  logic [3:0]  ded_in_i  = 4'h0;
  logic [31:0] io_in_i   = 32'h0000_0000;
  logic [31:0] io_out_o;
  logic [31:0] io_oe_o;
  int          n_errors  = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic        o;
  logic        e;
  mc_ctrl_type c;

  always #2 ref_clk_i = ~ref_clk_i;

  cpld_logic_macrocell dut_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .axi_req_i(axi_req_i),
    .axi_rsp_o(axi_rsp_o), .ded_in_i(ded_in_i), .io_in_i(io_in_i),
    .io_out_o(io_out_o), .io_oe_o(io_oe_o));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p  = 1'b1;
    axi_req_i.awaddr  <= a;
    axi_req_i.awvalid <= 1'b1;
    axi_req_i.wdata   <= d;
    axi_req_i.wstrb   <= 4'hf;
    axi_req_i.wvalid  <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge ref_clk_i);
      aw_p = aw_p && (axi_rsp_o.awready !== 1'b1);
      w_p  = w_p && (axi_rsp_o.wready !== 1'b1);
      @(posedge ref_clk_i);
      axi_req_i.awvalid <= aw_p;
      axi_req_i.wvalid  <= w_p;
    end
    do @(negedge ref_clk_i); while (axi_rsp_o.bvalid !== 1'b1);
    rs = axi_rsp_o.bresp;
    @(posedge ref_clk_i);
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] a);
    axi_req_i.araddr  <= a;
    axi_req_i.arvalid <= 1'b1;
    do @(negedge ref_clk_i); while (axi_rsp_o.arready !== 1'b1);
    @(posedge ref_clk_i);
    axi_req_i.arvalid <= 1'b0;
    do @(negedge ref_clk_i); while (axi_rsp_o.rvalid !== 1'b1);
    rd = axi_rsp_o.rdata;
    rs = axi_rsp_o.rresp;
    @(posedge ref_clk_i);
  endtask : axi_rd

  // drive pins, settle, snapshot macrocell 0 output and enable
  task automatic pins(input logic [3:0] d, input logic [31:0] io);
    ded_in_i <= d;
    io_in_i  <= io;
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    o = io_out_o[0];
    e = io_oe_o[0];
    @(posedge ref_clk_i);
  endtask : pins

  task automatic cfg();
    axi_wr(16'h1000, c);
    pins(ded_in_i, io_in_i);
  endtask : cfg

  initial begin
    axi_req_i        = '0;
    axi_req_i.bready = 1'b1;
    axi_req_i.rready = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    axi_rd(SIG_ADDR);
    check("sig reset", rd, {16'h0000, SIG_RESET});
    axi_wr(SIG_ADDR, 32'h0000_5a3c);
    axi_rd(SIG_ADDR);
    check("sig value", rd, 32'h0000_5a3c);
    axi_rd(16'h1100);
    check("unmapped resp", rs, RESP_SLVERR);
    axi_wr(QSTAT_ADDR, 32'h0000_0001);
    check("ro write resp", rs, RESP_SLVERR);
    $display("test bus done");
    axi_wr(16'h1400, 32'h0000_0004);
    axi_wr(16'h0000, 32'h0000_0001);
    axi_rd(16'h0000);
    check("pt mask", rd, 32'h0000_0001);
    c = '0;
    c.pt_to_sum = 5'h01;
    c.oe_mode   = OE_ON;
    cfg();
    pins(4'h0, 32'h0000_0001);
    check("comb out", o, 1'b1);
    check("oe on", e, 1'b1);
    c.xor_sel = XOR_HIGH;
    cfg();
    check("xor high", o, 1'b0);
    pins(4'h0, 32'h0000_0000);
    check("xor high low", o, 1'b1);
    $display("test comb done");
    c.d_sel   = D_PIN;
    c.out_reg = 1'b1;
    c.clk_sel = 2'h0;
    cfg();
    pins(4'h0, 32'h0000_0001);
    check("no edge", o, 1'b0);
    pins(4'h1, 32'h0000_0001);
    check("rising", o, 1'b1);
    pins(4'h1, 32'h0000_0000);
    check("hold high", o, 1'b1);
    pins(4'h0, 32'h0000_0000);
    check("falling", o, 1'b1);
    c.ff_mode = FF_T;
    cfg();
    pins(4'h1, 32'h0000_0001);
    check("toggle 1", o, 1'b0);
    pins(4'h0, 32'h0000_0001);
    pins(4'h1, 32'h0000_0001);
    check("toggle 2", o, 1'b1);
    c.ff_mode = FF_LATCH;
    cfg();
    pins(4'h1, 32'h0000_0000);
    check("latch pass 0", o, 1'b0);
    pins(4'h1, 32'h0000_0001);
    check("latch pass 1", o, 1'b1);
    pins(4'h0, 32'h0000_0001);
    pins(4'h0, 32'h0000_0000);
    check("latch hold", o, 1'b1);
    $display("test storage done");
    c.ff_mode = FF_D;
    c.set_en  = 1'b1;
    c.clr_sel = 2'h1;
    cfg();
    pins(4'h8, 32'h0000_0000);
    check("clear", o, 1'b0);
    pins(4'h0, 32'h0000_0000);
    check("set", o, 1'b1);
    c.oe_mode = OE_PIN;
    cfg();
    check("oe pin low", e, 1'b0);
    pins(4'h1, 32'h0000_0000);
    check("oe pin high", e, 1'b1);
    c.oe_inv = 1'b1;
    cfg();
    check("oe inverted", e, 1'b0);
    $display("test control done");
    axi_wr(16'h0084, 32'h0000_0100);
    axi_wr(16'h1004, 32'h0800_0000);
    pins(ded_in_i, 32'h0000_0001);
    axi_rd(OSTAT_ADDR);
    check("fold low", rd[1], 1'b0);
    pins(ded_in_i, 32'h0000_0000);
    axi_rd(OSTAT_ADDR);
    check("fold high", rd[1], 1'b1);
    axi_wr(16'h1004, 32'h0800_0001);
    pins(ded_in_i, 32'h0000_0001);
    axi_rd(OSTAT_ADDR);
    check("cascade", rd[1], 1'b1);
    $display("test routing done");
    axi_wr(LOCK_ADDR, 32'h0000_0001);
    axi_rd(16'h0000);
    check("locked mask", rd, 32'h0000_0000);
    check("locked resp", rs, RESP_OKAY);
    axi_rd(SIG_ADDR);
    check("locked sig", rd, 32'h0000_5a3c);
    $display("test lock done");
    tally_and_finish();
  end
endmodule : test_cpld_logic_macrocell
